// [hdl/ledcr_pkg.sv]
/*
 * package for the led driver control register bank: offsets, fields, resets, timing
 * assumes a 200 MHz mclk
 */
package ledcr_pkg;
    localparam logic [7:0] ADDR_GENCFG   = 8'h01;
    localparam logic [7:0] ADDR_AUXCTL   = 8'h02;
    localparam logic [7:0] ADDR_FADEON   = 8'h03;
    localparam logic [7:0] ADDR_FADEOFF  = 8'h04;
    localparam logic [7:0] ADDR_CH1CUR   = 8'h05;
    localparam logic [7:0] ADDR_CH2CUR   = 8'h06;
    localparam logic [7:0] ADDR_FAULT    = 8'h07;
    localparam logic [7:0] ADDR_OPENCFG  = 8'h08;
    localparam logic [7:0] ADDR_GUARD    = 8'h09;
    localparam logic [7:0] ADDR_PROTCFG  = 8'h0A;

    localparam logic [7:0] RST_GENCFG    = 8'h84;
    localparam logic [7:0] RST_AUXCTL    = 8'h00;
    localparam logic [7:0] RST_FADE      = 8'h64;
    localparam logic [7:0] RST_CUR       = 8'h00;
    localparam logic [7:0] RST_OPENCFG   = 8'h1A;
    localparam logic [7:0] RST_GUARD     = 8'h00;
    localparam logic [7:0] RST_PROTCFG   = 8'h78;
    localparam logic [7:0] UNLOCK_CODE   = 8'hC5;

    localparam logic [7:0] MASK_GENCFG   = 8'hFD;
    localparam logic [7:0] MASK_AUXCTL   = 8'h17;
    localparam logic [7:0] MASK_PROTCFG  = 8'h7F;

    localparam int BIT_TEMP = 7;
    localparam int BIT_BATT = 6;
    localparam int BIT_AUXS = 5;
    localparam int BIT_FONS = 4;
    localparam int BIT_FOFS = 3;
    localparam int BIT_PWMM = 2;
    localparam int BIT_ENM  = 0;
    localparam int BIT_AUXON = 4;
    localparam int BIT_DIM  = 7;

    localparam int  CLK_MHZ        = 200;
    localparam int  DEBOUNCE_MS    = 37;
    localparam int  DEBOUNCE_CYC   = DEBOUNCE_MS * 1000 * CLK_MHZ;
    localparam int  FADE_STEP_MS   = 7;
    localparam int  FADE_STEP_CYC  = FADE_STEP_MS * 1000 * CLK_MHZ;
    localparam int  FADE_MIN_US    = 75;
    localparam int  FADE_MIN_CYC   = FADE_MIN_US * CLK_MHZ;

    typedef struct packed {
        logic [2:0] openFlags;
        logic [2:0] shortFlags;
        logic       overheat;
    } ledcr_fault_t;

    typedef struct packed {
        logic       thermalRolloff;
        logic       battery24;
        logic       fadeOnFromReg;
        logic       fadeOffFromReg;
        logic       pwmExternal;
        logic       pulseMode;
        logic [2:0] auxCurrentStep;
        logic [7:0] ch1Scale;
        logic [7:0] ch2Scale;
        logic [31:0] fadeOnCycles;
        logic [31:0] fadeOffCycles;
    } ledcr_ctl_t;
endpackage : ledcr_pkg

// [hdl/ledcr_regs.sv]
/*
 * led driver control register bank with enable-pin handling and dimming control
 * assumes the serial protocol engine gives byte-wide write/read strobes; inputs synchronous
 */
`timescale 1ns/100ps
module ledcr_regs (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  xferStart,
    input  wire logic [7:0]            xferAddr,
    input  wire logic                  wrStrobe,
    input  wire logic [7:0]            wrData,
    input  wire logic                  rdStrobe,
    output logic [7:0]                 rdData,
    input  wire ledcr_pkg::ledcr_fault_t faultIn,
    input  wire logic [1:0]            channel_enable_pins,
    input  wire logic                  auxEnablePin,
    output ledcr_pkg::ledcr_ctl_t      ctl,
    output logic [1:0]                 channelOn,
    output logic                       aux_channel_on,
    output logic                       rampUp,
    output logic                       dimDirect
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] genCfg_ff, auxCtl_ff, fadeOn_ff, fadeOff_ff, ch1_ff, ch2_ff;
    logic [7:0] openCfg_ff, guard_ff, protCfg_ff, ptr_ff;
    logic       dim_ff;
    logic [1:0] pinStable_ff, pinPrev_ff, chanState_ff;
    logic [31:0] dbCnt_ff [2];
    logic       unlocked;
    logic [7:0] wrAddr;

    function automatic logic [31:0] fadeCycles(input logic [7:0] code);
        fadeCycles = (code == 8'h00) ? 32'(ledcr_pkg::FADE_MIN_CYC)
                                     : 32'(code) * 32'(ledcr_pkg::FADE_STEP_CYC);
    endfunction : fadeCycles

    assign unlocked = (guard_ff == ledcr_pkg::UNLOCK_CODE);
    assign wrAddr   = xferStart ? xferAddr : ptr_ff;

    // ----------------------------------------
    // register pointer
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ptr_ff <= 8'h00;
        end else if (wrStrobe || rdStrobe) begin
            ptr_ff <= wrAddr + 8'h01;
        end else if (xferStart) begin
            ptr_ff <= xferAddr;
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            genCfg_ff  <= ledcr_pkg::RST_GENCFG;
            auxCtl_ff  <= ledcr_pkg::RST_AUXCTL;
            fadeOn_ff  <= ledcr_pkg::RST_FADE;
            fadeOff_ff <= ledcr_pkg::RST_FADE;
            ch1_ff     <= ledcr_pkg::RST_CUR;
            ch2_ff     <= ledcr_pkg::RST_CUR;
            openCfg_ff <= ledcr_pkg::RST_OPENCFG;
            guard_ff   <= ledcr_pkg::RST_GUARD;
            protCfg_ff <= ledcr_pkg::RST_PROTCFG;
            dim_ff     <= 1'b0;
        end else if (wrStrobe) begin
            if (wrAddr == ledcr_pkg::ADDR_GUARD) begin
                guard_ff <= wrData;
            end else if (unlocked) begin
                unique case (wrAddr)
                    ledcr_pkg::ADDR_GENCFG:  genCfg_ff  <= wrData & ledcr_pkg::MASK_GENCFG;
                    ledcr_pkg::ADDR_AUXCTL:  auxCtl_ff  <= wrData & ledcr_pkg::MASK_AUXCTL;
                    ledcr_pkg::ADDR_FADEON:  fadeOn_ff  <= wrData;
                    ledcr_pkg::ADDR_FADEOFF: fadeOff_ff <= wrData;
                    ledcr_pkg::ADDR_CH1CUR:  ch1_ff     <= wrData;
                    ledcr_pkg::ADDR_CH2CUR:  ch2_ff     <= wrData;
                    ledcr_pkg::ADDR_FAULT:   dim_ff     <= wrData[ledcr_pkg::BIT_DIM];
                    ledcr_pkg::ADDR_OPENCFG: openCfg_ff <= wrData;
                    ledcr_pkg::ADDR_PROTCFG: protCfg_ff <= wrData & ledcr_pkg::MASK_PROTCFG;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdData <= 8'h00;
        end else if (rdStrobe) begin
            unique case (wrAddr)
                ledcr_pkg::ADDR_GENCFG:  rdData <= genCfg_ff;
                ledcr_pkg::ADDR_AUXCTL:  rdData <= auxCtl_ff;
                ledcr_pkg::ADDR_FADEON:  rdData <= fadeOn_ff;
                ledcr_pkg::ADDR_FADEOFF: rdData <= fadeOff_ff;
                ledcr_pkg::ADDR_CH1CUR:  rdData <= ch1_ff;
                ledcr_pkg::ADDR_CH2CUR:  rdData <= ch2_ff;
                ledcr_pkg::ADDR_FAULT:   rdData <= {dim_ff, faultIn.overheat,
                                                   faultIn.openFlags,
                                                   faultIn.shortFlags};
                ledcr_pkg::ADDR_OPENCFG: rdData <= openCfg_ff;
                ledcr_pkg::ADDR_GUARD:   rdData <= guard_ff;
                ledcr_pkg::ADDR_PROTCFG: rdData <= protCfg_ff;
                default:                 rdData <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // enable pin debounce and mode
    // ----------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_pin
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                dbCnt_ff[ch]     <= 32'h00000000;
                pinStable_ff[ch] <= 1'b0;
                pinPrev_ff[ch]   <= 1'b0;
                chanState_ff[ch] <= 1'b0;
            end else begin
                pinPrev_ff[ch] <= pinStable_ff[ch];
                if (channel_enable_pins[ch] == pinStable_ff[ch]) begin
                    dbCnt_ff[ch] <= 32'h00000000;
                end else if (dbCnt_ff[ch] >= 32'(ledcr_pkg::DEBOUNCE_CYC - 1)) begin
                    dbCnt_ff[ch]     <= 32'h00000000;
                    pinStable_ff[ch] <= channel_enable_pins[ch];
                end else begin
                    dbCnt_ff[ch] <= dbCnt_ff[ch] + 32'h00000001;
                end
                if (genCfg_ff[ledcr_pkg::BIT_ENM]) begin
                    if (pinPrev_ff[ch] && !pinStable_ff[ch]) begin
                        chanState_ff[ch] <= !chanState_ff[ch];
                    end
                end else begin
                    chanState_ff[ch] <= pinStable_ff[ch];
                end
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctl            <= '0;
            channelOn      <= 2'b00;
            aux_channel_on <= 1'b0;
            rampUp         <= 1'b0;
            dimDirect      <= 1'b0;
        end else begin
            ctl.thermalRolloff <= genCfg_ff[ledcr_pkg::BIT_TEMP];
            ctl.battery24      <= genCfg_ff[ledcr_pkg::BIT_BATT];
            ctl.fadeOnFromReg  <= genCfg_ff[ledcr_pkg::BIT_FONS];
            ctl.fadeOffFromReg <= genCfg_ff[ledcr_pkg::BIT_FOFS];
            ctl.pwmExternal    <= genCfg_ff[ledcr_pkg::BIT_PWMM];
            ctl.pulseMode      <= genCfg_ff[ledcr_pkg::BIT_ENM];
            ctl.auxCurrentStep <= auxCtl_ff[2:0];
            ctl.ch1Scale       <= ch1_ff;
            ctl.ch2Scale       <= ch2_ff;
            ctl.fadeOnCycles   <= fadeCycles(fadeOn_ff);
            ctl.fadeOffCycles  <= fadeCycles(fadeOff_ff);
            channelOn          <= chanState_ff;
            aux_channel_on     <= genCfg_ff[ledcr_pkg::BIT_AUXS]
                                  ? auxCtl_ff[ledcr_pkg::BIT_AUXON]
                                  : auxEnablePin;
            dimDirect          <= genCfg_ff[ledcr_pkg::BIT_PWMM] & dim_ff;
            rampUp             <= ~genCfg_ff[ledcr_pkg::BIT_PWMM] & dim_ff;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_LOCKED_WRITE: assert property (@(posedge mclk) disable iff (!resetn)
        (wrStrobe && !unlocked && wrAddr == ledcr_pkg::ADDR_CH1CUR) |=> $stable(ch1_ff))
        else $error("locked write changed a register");
    AST_PTR_INC: assert property (@(posedge mclk) disable iff (!resetn)
        wrStrobe |=> ptr_ff == $past(wrAddr) + 8'h01)
        else $error("pointer did not advance");
    AST_AUX_REG: assert property (@(posedge mclk) disable iff (!resetn)
        (genCfg_ff[ledcr_pkg::BIT_AUXS] && $stable(auxCtl_ff)) |=>
        aux_channel_on == $past(auxCtl_ff[ledcr_pkg::BIT_AUXON]))
        else $error("aux output not from register");
    AST_AUX_PIN: assert property (@(posedge mclk) disable iff (!resetn)
        !genCfg_ff[ledcr_pkg::BIT_AUXS] |=> aux_channel_on == $past(auxEnablePin))
        else $error("aux output not from pin");
    AST_RESERVED: assert property (@(posedge mclk) disable iff (!resetn)
        (auxCtl_ff & ~ledcr_pkg::MASK_AUXCTL) == 8'h00 && genCfg_ff[1] == 1'b0)
        else $error("reserved bit set");
    AST_FAULT_RO: assert property (@(posedge mclk) disable iff (!resetn)
        (rdStrobe && wrAddr == ledcr_pkg::ADDR_FAULT) |=>
        rdData[5:0] == $past({faultIn.openFlags, faultIn.shortFlags}))
        else $error("fault flags misreported");
    AST_DIM_EXT: assert property (@(posedge mclk) disable iff (!resetn)
        (genCfg_ff[ledcr_pkg::BIT_PWMM] && dim_ff) ##1 $stable(dim_ff) |-> dimDirect && !rampUp)
        else $error("external dimming wrong");
    AST_LEVEL: assert property (@(posedge mclk) disable iff (!resetn)
        (!genCfg_ff[ledcr_pkg::BIT_ENM] && $stable(genCfg_ff)) |=>
        chanState_ff == $past(pinStable_ff))
        else $error("level mode not following pin");
endmodule : ledcr_regs

// [testbench/ledcr_master.sv]
/*
 * bus master model that drives the register bank's byte strobes
 * assumes inputs change at the falling mclk edge and rdData is registered
 */
`timescale 1ns/100ps
module ledcr_master (
    input  wire logic       mclk,
    output logic            xferStart,
    output logic [7:0]      xferAddr,
    output logic            wrStrobe,
    output logic [7:0]      wrData,
    output logic            rdStrobe,
    input  wire logic [7:0] rdData
);
    initial begin
        xferStart = 1'b0;
        xferAddr  = 8'h00;
        wrStrobe  = 1'b0;
        wrData    = 8'h00;
        rdStrobe  = 1'b0;
    end

    // ------------------------------------------------------------
    // write: address given in the same cycle as the first data byte, then back-to-back data bytes
    // ------------------------------------------------------------
    task automatic writeBurst(input logic [7:0] addr, input logic [7:0] bytes[$]);
        foreach (bytes[i]) begin
            @(negedge mclk);
            xferStart = (i == 0);
            xferAddr  = (i == 0) ? addr : ~addr;
            wrStrobe  = 1'b1;
            wrData    = bytes[i];
        end
        @(negedge mclk);
        xferStart = 1'b0;
        xferAddr  = ~addr;
        wrStrobe  = 1'b0;
        wrData    = ~wrData;
    endtask : writeBurst

    // ------------------------------------------------------------
    // read: address phase, read strobe, data taken one cycle later
    // ------------------------------------------------------------
    task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge mclk);
        xferStart = 1'b1;
        xferAddr  = addr;
        @(negedge mclk);
        xferStart = 1'b0;
        xferAddr  = ~addr;
        rdStrobe  = 1'b1;
        @(negedge mclk);
        rdStrobe  = 1'b0;
        data      = rdData;
    endtask : readReg
endmodule : ledcr_master

// [testbench/tb_top.sv]
/*
 * self-checking bench for the led driver register bank
 * assumes the master model and the package; enable pins go high only briefly (debounce too long)
 */
`timescale 1ns/100ps
module tb_top;
    logic                    mclk = 1'b0;
    logic                    resetn = 1'b0;
    logic                    xferStart, wrStrobe, rdStrobe, auxOn, rampUp, dimDirect;
    logic [7:0]              xferAddr, wrData, rdData, rv;
    logic [1:0]              channelOn;
    logic                    auxPin = 1'b0;
    logic [1:0]              enPins = 2'b00;
    ledcr_pkg::ledcr_fault_t faultIn = '0;
    ledcr_pkg::ledcr_ctl_t   ctl;
    int                      errTotal = 0;
    int                      nCompared = 0;
    logic [7:0]              rstTab [0:11] = '{8'h00, 8'h84, 8'h00, 8'h64, 8'h64, 8'h00,
                                               8'h00, 8'h00, 8'h1A, 8'h00, 8'h78, 8'h00};

    always #2.5 mclk = ~mclk;

    ledcr_master u_master (.mclk(mclk), .xferStart(xferStart), .xferAddr(xferAddr),
        .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe), .rdData(rdData));

    ledcr_regs u_dut (.mclk(mclk), .resetn(resetn), .xferStart(xferStart),
        .xferAddr(xferAddr), .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
        .rdData(rdData), .faultIn(faultIn), .channel_enable_pins(enPins),
        .auxEnablePin(auxPin), .ctl(ctl), .channelOn(channelOn), .aux_channel_on(auxOn),
        .rampUp(rampUp), .dimDirect(dimDirect));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
        u_master.readReg(addr, rv);
        check($sformatf("reg %h", addr), {24'h0, rv}, {24'h0, exp});
    endtask : rdChk

    task automatic settle();
        repeat (3) @(negedge mclk);
    endtask : settle

    task automatic reportAndStop();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : reportAndStop

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        reportAndStop();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        for (int i = 0; i < 12; i++) rdChk(i[7:0], rstTab[i]);
        u_master.writeBurst(8'h05, '{8'h80});
        rdChk(8'h05, 8'h00);
        u_master.writeBurst(8'h09, '{8'hC5});
        u_master.writeBurst(8'h01, '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hAB, 8'hCD, 8'hFF});
        rdChk(8'h01, 8'hFD);
        rdChk(8'h02, 8'h17);
        rdChk(8'h03, 8'hFF);
        rdChk(8'h04, 8'hFF);
        rdChk(8'h05, 8'hAB);
        rdChk(8'h06, 8'hCD);
        rdChk(8'h07, 8'h80);
        check("flags", {ctl.thermalRolloff, ctl.battery24, ctl.fadeOnFromReg,
            ctl.fadeOffFromReg, ctl.pwmExternal, ctl.pulseMode}, 32'h3F);
        check("auxStep", ctl.auxCurrentStep, 32'h7);
        check("scales", {ctl.ch1Scale, ctl.ch2Scale}, 32'hABCD);
        check("fadeOn", ctl.fadeOnCycles, 255 * ledcr_pkg::FADE_STEP_CYC);
        check("fadeOff", ctl.fadeOffCycles, 255 * ledcr_pkg::FADE_STEP_CYC);
        check("auxReg", auxOn, 32'h1);
        check("direct", {dimDirect, rampUp}, 32'h2);
        check("chOn", channelOn, 32'h0);
        faultIn = '{openFlags: 3'b101, shortFlags: 3'b010, overheat: 1'b1};
        u_master.writeBurst(8'h07, '{8'h7F});
        rdChk(8'h07, 8'h6A);
        settle();
        check("offDirect", {dimDirect, rampUp}, 32'h0);
        u_master.writeBurst(8'h01, '{8'h18});
        u_master.writeBurst(8'h07, '{8'h80});
        u_master.writeBurst(8'h03, '{8'h00, 8'h01});
        settle();
        check("flags2", {ctl.thermalRolloff, ctl.battery24, ctl.fadeOnFromReg,
            ctl.fadeOffFromReg, ctl.pwmExternal, ctl.pulseMode}, 32'h0C);
        check("fadeMin", ctl.fadeOnCycles, ledcr_pkg::FADE_MIN_CYC);
        check("fadeOne", ctl.fadeOffCycles, ledcr_pkg::FADE_STEP_CYC);
        check("ramp", {dimDirect, rampUp}, 32'h1);
        check("auxPinLo", auxOn, 32'h0);
        auxPin = 1'b1;
        settle();
        check("auxPinHi", auxOn, 32'h1);
        enPins = 2'b11;
        settle();
        check("chDebounce", channelOn, 32'h0);
        enPins = 2'b00;
        u_master.writeBurst(8'h09, '{8'h00});
        u_master.writeBurst(8'h05, '{8'h11});
        rdChk(8'h05, 8'hAB);
        reportAndStop();
    end
endmodule : tb_top
